// [verilog/ettc_regs.svh]
`ifndef ETTC_REGS_SVH
`define ETTC_REGS_SVH

// register word addresses
`define ETTC_ADDR_COUNT 8'h00
`define ETTC_ADDR_OPTION 8'h01
`define ETTC_ADDR_INTCTL 8'h02

// option register fields
`define ETTC_OPT_CS 5
`define ETTC_OPT_SE 4
`define ETTC_OPT_PSA 3
`define ETTC_OPT_PS_HI 2
`define ETTC_OPT_PS_LO 0
`define ETTC_OPT_RST 6'h08

// interrupt control register fields
`define ETTC_ICR_IE 5
`define ETTC_ICR_FLAG 2

// counting constants
`define ETTC_COUNT_MAX 8'hFF
`define ETTC_COUNT_RST 8'h00
`define ETTC_HOLDOFF 2'h2
`define ETTC_PRE_FULL 8'hFF
`define ETTC_PS_TOP 3'h7

// instruction cycle timing
`define ETTC_CLK_NS 10
`define ETTC_TCY_NS 40
`define ETTC_TCY_CLKS (`ETTC_TCY_NS / `ETTC_CLK_NS)
`define ETTC_DIV_LAST 2'((`ETTC_TCY_CLKS) - 1)

`endif

// [verilog/ettc_pkg.sv]
`default_nettype none
package ettc_pkg;

	// one register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ettc_bus_req_type;

	// every flip-flop of the timer
	typedef struct packed {
		logic [7:0] count;
		logic [5:0] opt;
		logic ie;
		logic flag;
		logic [1:0] inhibit;
		logic [1:0] div;
		logic [7:0] pre;
		logic wdt_tick;
		logic ext_s1;
		logic ext_s2;
		logic ext_d;
		logic [7:0] rdata;
	} ettc_state_type;

endpackage : ettc_pkg
`default_nettype wire

// [verilog/ettc_timer.sv]
`include "ettc_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module ettc_timer (
	input wire logic SYS_CLK_I,
	input wire logic NRST_I,
	input wire ettc_pkg::ettc_bus_req_type REQ_I,
	input wire logic SLEEP_I,
	input wire logic EXT_COUNT_I,
	input wire logic WDT_RAW_I,
	output logic [7:0] RDATA_O,
	output logic IRQ_O,
	output logic WDT_TICK_O
);

	ettc_pkg::ettc_state_type s_r;
	ettc_pkg::ettc_state_type s_nxt;
	logic tcy;
	logic ext_edge;
	logic run;
	logic timer_src;
	logic pre_src;
	logic pre_hit;
	logic inc;
	logic ovf;
	logic psa;
	logic wr_count;
	logic wr_icr;
	logic [7:0] pre_mask;

	// decode of the register port
	assign wr_count = REQ_I.wr && (REQ_I.addr == `ETTC_ADDR_COUNT);
	assign wr_icr = REQ_I.wr && (REQ_I.addr == `ETTC_ADDR_INTCTL);
	assign psa = s_r.opt[`ETTC_OPT_PSA];

	// next-state logic for the whole timer
	always_comb begin
		s_nxt = s_r;
		// two-flop synchroniser, only the second stage feeds the edge detector
		s_nxt.ext_s1 = EXT_COUNT_I;
		s_nxt.ext_s2 = s_r.ext_s1;
		s_nxt.ext_d = s_r.ext_s2;
		// edge select inverts the sense of the detector
		ext_edge = s_r.opt[`ETTC_OPT_SE] ? (s_r.ext_d && !s_r.ext_s2)
			: (s_r.ext_s2 && !s_r.ext_d);
		// instruction cycle enable from the system clock divider
		tcy = (s_r.div == `ETTC_DIV_LAST);
		s_nxt.div = tcy ? 2'h0 : s_r.div + 2'h1;
		// sleep and the post-write hold-off both freeze the count
		run = !SLEEP_I && (s_r.inhibit == 2'h0);
		if (tcy && (s_r.inhibit != 2'h0)) begin
			s_nxt.inhibit = s_r.inhibit - 2'h1;
		end
		timer_src = run && (s_r.opt[`ETTC_OPT_CS] ? ext_edge : tcy);
		// prescaler belongs to exactly one user at a time
		pre_mask = `ETTC_PRE_FULL >> (`ETTC_PS_TOP - s_r.opt[`ETTC_OPT_PS_HI:`ETTC_OPT_PS_LO]);
		pre_src = psa ? WDT_RAW_I : timer_src;
		pre_hit = pre_src && ((s_r.pre & pre_mask) == pre_mask);
		if (pre_src) begin
			s_nxt.pre = s_r.pre + 8'h01;
		end
		s_nxt.wdt_tick = psa && pre_hit;
		inc = psa ? timer_src : pre_hit;
		ovf = inc && (s_r.count == `ETTC_COUNT_MAX);
		if (inc) begin
			s_nxt.count = s_r.count + 8'h01;
		end
		if (ovf) begin
			s_nxt.flag = 1'b1;
		end
		// software writes; a write to the count wins over the step
		if (wr_count) begin
			s_nxt.count = REQ_I.wdata;
			s_nxt.inhibit = `ETTC_HOLDOFF;
			if (!psa) begin
				s_nxt.pre = 8'h00;
			end
		end
		if (REQ_I.wr && (REQ_I.addr == `ETTC_ADDR_OPTION)) begin
			s_nxt.opt = REQ_I.wdata[5:0];
		end
		if (wr_icr) begin
			s_nxt.ie = REQ_I.wdata[`ETTC_ICR_IE];
			// a same-cycle overflow beats the software clear
			s_nxt.flag = REQ_I.wdata[`ETTC_ICR_FLAG] || ovf;
		end
		// read data valid only in the cycle after the strobe
		s_nxt.rdata = 8'h00;
		if (REQ_I.rd) begin
			case (REQ_I.addr)
				`ETTC_ADDR_COUNT: begin
					s_nxt.rdata = s_r.count;
				end
				`ETTC_ADDR_OPTION: begin
					s_nxt.rdata = {2'b00, s_r.opt};
				end
				`ETTC_ADDR_INTCTL: begin
					s_nxt.rdata = {2'b00, s_r.ie, 2'b00, s_r.flag, 2'b00};
				end
				default: begin
					s_nxt.rdata = 8'h00;
				end
			endcase
		end
	end

	// state register
	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			s_r <= '0;
			s_r.opt <= `ETTC_OPT_RST;
			s_r.count <= `ETTC_COUNT_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs; the request is masked by the enable bit
	assign RDATA_O = s_r.rdata;
	assign IRQ_O = s_r.flag && s_r.ie;
	assign WDT_TICK_O = s_r.wdt_tick;

	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (!NRST_I);

	a_ovf_sets_flag: assert property (ovf && !wr_count && !wr_icr
		|=> s_r.flag && s_r.count == 8'h00)
		else $error("overflow did not wrap and set flag");
	a_irq_masked: assert property (!s_r.ie |-> !IRQ_O)
		else $error("interrupt request not masked");
	a_flag_sticky: assert property (s_r.flag && !wr_icr |=> s_r.flag)
		else $error("overflow flag cleared by hardware");
	a_timer_step: assert property (tcy && !s_r.opt[`ETTC_OPT_CS] && psa && !SLEEP_I
		&& s_r.inhibit == 2'h0 && !wr_count |=> s_r.count == $past(s_r.count) + 8'h01)
		else $error("timer mode missed an instruction cycle");
	a_holdoff_two: assert property (wr_count ##1 (!wr_count && !tcy) [*1] |-> s_r.inhibit != 2'h0
		&& s_r.count == $past(REQ_I.wdata, 1))
		else $error("count moved right after a write");
	a_holdoff_hold: assert property (s_r.inhibit != 2'h0 && !wr_count
		|=> s_r.count == $past(s_r.count))
		else $error("count stepped during hold-off");
	a_counter_edge: assert property (s_r.opt[`ETTC_OPT_CS] && ext_edge && psa && run && !wr_count
		|=> s_r.count == $past(s_r.count) + 8'h01)
		else $error("counter mode missed a selected edge");
	a_no_tcy_count: assert property (s_r.opt[`ETTC_OPT_CS] && !ext_edge && !wr_count
		|=> s_r.count == $past(s_r.count))
		else $error("counter mode stepped without an edge");
	a_prescaler_owner: assert property (!psa |=> !WDT_TICK_O)
		else $error("watchdog ticked while prescaler owned by timer");
	a_sleep_frozen: assert property (SLEEP_I && !wr_count |=> s_r.count == $past(s_r.count)
		&& ($past(s_r.flag) || !s_r.flag || $past(wr_icr)))
		else $error("timer ran during sleep");
	a_sync_edge: assert property (s_r.opt[`ETTC_OPT_SE] == 1'b0 && ext_edge
		|-> $past(EXT_COUNT_I, 2) && !$past(EXT_COUNT_I, 3))
		else $error("edge seen without synchronised input");

	// falling-edge mode sees a high then a low after the two flops
	a_counter_falling: assert property (s_r.opt[`ETTC_OPT_SE] && ext_edge
		|-> !$past(EXT_COUNT_I, 2) && $past(EXT_COUNT_I, 3))
		else $error("falling edge seen without synchronised input");

	// software readback of the count, one cycle after the strobe
	a_read_count: assert property (REQ_I.rd && REQ_I.addr == `ETTC_ADDR_COUNT
		|=> RDATA_O == $past(s_r.count))
		else $error("count readback wrong");

	// prescaler has no address, so unmapped reads give zero
	a_read_unmapped: assert property (REQ_I.rd && REQ_I.addr > `ETTC_ADDR_INTCTL
		|=> RDATA_O == 8'h00)
		else $error("unmapped read not zero");

	// flag bit readback
	a_read_flag: assert property (REQ_I.rd && REQ_I.addr == `ETTC_ADDR_INTCTL
		|=> RDATA_O[`ETTC_ICR_FLAG] == $past(s_r.flag))
		else $error("flag readback wrong");

	// enable bit readback
	a_read_enable: assert property (REQ_I.rd && REQ_I.addr == `ETTC_ADDR_INTCTL
		|=> RDATA_O[`ETTC_ICR_IE] == $past(s_r.ie))
		else $error("enable readback wrong");

	// an overflow beats a clear written in the same cycle
	a_flag_set_wins: assert property (ovf && wr_icr
		|=> s_r.flag)
		else $error("same-cycle clear beat the overflow");

	// an enabled, set flag must reach the request pin
	a_irq_follows: assert property (s_r.flag && s_r.ie
		|-> IRQ_O)
		else $error("enabled flag gave no request");

	// a count write loads the value and arms the hold-off
	a_write_loads: assert property (wr_count
		|=> s_r.count == $past(REQ_I.wdata) && s_r.inhibit == `ETTC_HOLDOFF)
		else $error("count write not loaded");

	// hold-off only drains on instruction cycles
	a_inhibit_steps: assert property (tcy && s_r.inhibit != 2'h0 && !wr_count
		|=> s_r.inhibit == $past(s_r.inhibit) - 2'h1)
		else $error("hold-off did not drain");

	// instruction cycle enable is a single pulse every four clocks
	a_tcy_spacing: assert property (tcy
		|-> ##1 !tcy ##3 tcy)
		else $error("instruction cycle spacing wrong");

	// watchdog ticks only from raw pulses while it owns the prescaler
	a_wdt_tick_cause: assert property (WDT_TICK_O
		|-> $past(WDT_RAW_I) && $past(psa))
		else $error("watchdog tick without cause");

	// sleep can never produce an overflow
	a_sleep_no_ovf: assert property (SLEEP_I
		|-> !ovf)
		else $error("overflow during sleep");

	// option write takes the low six bits
	a_option_write: assert property (REQ_I.wr && REQ_I.addr == `ETTC_ADDR_OPTION
		|=> s_r.opt == $past(REQ_I.wdata[5:0]))
		else $error("option write not taken");

endmodule : ettc_timer
`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic sys_clk, rst_n, sleep, ext_in, irq, wdt_tick;
	ettc_pkg::ettc_bus_req_type req;
	logic [7:0] rdata, v, w;
	int bad_count = 0;
	int checks_done = 0;
	int x, n;
	int ticks = 0;
	logic wdt_raw;
	ettc_timer uut (.SYS_CLK_I(sys_clk), .NRST_I(rst_n), .REQ_I(req), .SLEEP_I(sleep),
		.EXT_COUNT_I(ext_in), .WDT_RAW_I(wdt_raw), .RDATA_O(rdata), .IRQ_O(irq),
		.WDT_TICK_O(wdt_tick));
	// count watchdog ticks away from the launching edge
	always @(negedge sys_clk) begin
		if (wdt_tick === 1'b1) begin
			ticks++;
		end
	end
	// compare one result with the integer model
	task automatic chk(input logic [7:0] got, input int exp);
		checks_done++;
		if (got !== 8'(exp)) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, 8'(exp));
		end
	endtask : chk
	// one-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		req.wr <= 1'b0;
		@(posedge sys_clk);
	endtask : wr
	// read data only stands in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] got);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		req.rd <= 1'b0;
		@(negedge sys_clk);
		got = rdata;
		@(posedge sys_clk);
	endtask : rd
	task automatic print_verdict();
		$display("checks %0d errors %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : print_verdict
	// free-running clock, 10 ns
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// run is about 1.5k cycles, so this only fires on a hang
	initial begin
		#100us;
		bad_count++;
		print_verdict();
	end
	// main sequence; windows of 40 clocks hold exactly ten instruction cycles
	initial begin
		rst_n = 1'b0;
		sleep = 1'b0;
		ext_in = 1'b0;
		wdt_raw = 1'b0;
		req = '0;
		void'($urandom(32'h0000_3fb6));
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(8'h00, v); chk(v, 0);
		rd(8'h01, v); chk(v, 8'h08);
		rd(8'h02, v); chk(v, 0);
		rd(8'h7f, v); chk(v, 0);
		rd(8'h00, v); repeat (38) @(posedge sys_clk);
		rd(8'h00, w); chk(w, int'(v) + 10);
		x = $urandom_range(0, 255);
		wr(8'h00, 8'(x)); repeat (39) @(posedge sys_clk);
		rd(8'h00, v); chk(v, x + 8);
		wr(8'h02, 8'h00);
		wr(8'h00, 8'hfd); repeat (39) @(posedge sys_clk);
		rd(8'h00, v); chk(v, 8'h05);
		rd(8'h02, v); chk(v, 8'h04);
		chk({7'h00, irq}, 0);
		wr(8'h02, 8'h20); chk({7'h00, irq}, 0);
		repeat (1040) @(posedge sys_clk);
		chk({7'h00, irq}, 1);
		sleep <= 1'b1;
		rd(8'h00, v); repeat (38) @(posedge sys_clk);
		rd(8'h00, w); chk(w, v);
		sleep <= 1'b0;
		// prescaler on the timer at 1:2, cleared by the count write
		wr(8'h01, 8'h00);
		wr(8'h00, 8'(x)); repeat (39) @(posedge sys_clk);
		rd(8'h00, v); chk(v, x + 4);
		// odd toggle count from high: falls outnumber rises by one
		for (int se = 0; se < 2; se++) begin
			ext_in <= 1'b1;
			repeat (8) @(posedge sys_clk);
			wr(8'h01, se ? 8'h38 : 8'h28);
			wr(8'h00, 8'h00);
			repeat (16) @(posedge sys_clk);
			n = $urandom_range(1, 6);
			repeat (2 * n + 1) begin
				ext_in <= ~ext_in;
				repeat (8) @(posedge sys_clk);
			end
			rd(8'h00, v); chk(v, n + se);
		end
		// watchdog owns the prescaler at 1:2, one tick per two raw pulses
		n = $urandom_range(1, 8);
		wdt_raw <= 1'b1;
		repeat (2 * n) @(posedge sys_clk);
		wdt_raw <= 1'b0;
		repeat (2) @(posedge sys_clk);
		chk(8'(ticks), n);
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire
